// [smp_regs.vh]
// Constants shared by the program message parser
`ifndef SMP_REGS_VH
`define SMP_REGS_VH

// ----------------------------------------
// Character codes
// ----------------------------------------
`define SMP_CH_LF 8'h0A
`define SMP_CH_SP 8'h20
`define SMP_CH_STAR 8'h2A
`define SMP_CH_COLON 8'h3A
`define SMP_CH_SEMI 8'h3B
`define SMP_CH_QMARK 8'h3F
`define SMP_CASE_OFS 8'h20

// ----------------------------------------
// Sizes
// ----------------------------------------
`define SMP_DW 8
`define SMP_FIFO_DEPTH 32
`define SMP_FIFO_AW 5
`define SMP_KW_MAX 4'hC
`define SMP_KW_BITS 96

// ----------------------------------------
// Tree nodes
// ----------------------------------------
`define SMP_NODE_W 5
`define SMP_NODE_ROOT 5'h00
`define SMP_NODE_LAST 29

`endif

// [smp_parser.v]
// Program message parser with its input FIFO
`timescale 1ns/1ps
`include "smp_regs.vh"

// ----------------------------------------
// Byte FIFO
// ----------------------------------------
module smp_fifo #(
  parameter W = 8,
  parameter D = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Filling side
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  // Draining side
  output wire [W-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;
  wire [AW:0] nxt_cnt;

  // Full and empty come from the next count so they never lag a cycle
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_ff[rd_ff];

  // Storage holds data only, so it needs no reset
  always @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers, count and flags
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ff <= wr_ff + {{(AW-1){1'b0}}, push};
      rd_ff <= rd_ff + {{(AW-1){1'b0}}, pop};
      cnt_ff <= nxt_cnt;
      in_ready <= (nxt_cnt != D[AW:0]);
      out_valid <= (nxt_cnt != {(AW+1){1'b0}});
    end
  end
endmodule // smp_fifo

// Functional notes
// - '?' after the last keyword makes the command a query.
// - Arguments come only after the last keyword of a command.
// - A space after the last keyword starts the parameter field.
// - A semicolon separates adjacent message units.
// - A leading colon sends the tree position to root first.
// - Line feed alone ends a program message.
// - Terminator or root specifier returns the tree position to root.
// - Optional keywords may be skipped; resolution is unchanged.
// - Voltage, current and function branches also resolve at root.
// - Root knows the eleven subsystem keywords as branch starts.
// - A colon between keywords descends one tree level.
// - A unit without leading colon resumes at previous keyword's parent.
// - The first unit of a message starts at root.
// - A unit starting with '*' is a common command or query.
// - Only the short form or the full long form matches.
// - Keyword matching ignores letter case.
// - Short form: whole word up to four letters, else four or three.
// - Any other truncation is rejected as an error.
// - Keywords inside a command are joined by colons.
module smp_parser (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Incoming character stream
  input wire [7:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Result consumer handshake
  input wire evt_ready,
  // Parsed units
  output reg unit_valid_ff,
  output reg [4:0] unit_node_ff,
  output reg unit_query_ff,
  output reg unit_common_ff,
  output reg unit_err_ff,
  output reg msg_end_ff,
  // Parameter characters
  output reg par_valid_ff,
  output reg [7:0] par_data_ff
);
  localparam ST_START = 3'h0;
  localparam ST_KW = 3'h1;
  localparam ST_QRY = 3'h2;
  localparam ST_PARAM = 3'h3;
  localparam ST_COMMON = 3'h4;
  localparam ST_SKIP = 3'h5;

  // ----------------------------------------
  // Keyword tree
  // ----------------------------------------

  // Long spellings, right justified, upper case
  function [95:0] kw_name;
    input [4:0] i;
    begin
      case (i)
        5'h01: kw_name = "ABORT";
        5'h02: kw_name = "CALIBRATE";
        5'h03: kw_name = "DISPLAY";
        5'h04: kw_name = "INITIATE";
        5'h05: kw_name = "LIST";
        5'h06: kw_name = "MEASURE";
        5'h07: kw_name = "OUTPUT";
        5'h08: kw_name = "SOURCE";
        5'h09: kw_name = "STATUS";
        5'h0A: kw_name = "SYSTEM";
        5'h0B: kw_name = "TRIGGER";
        5'h0C: kw_name = "VOLTAGE";
        5'h0D: kw_name = "CURRENT";
        5'h0E: kw_name = "FUNCTION";
        5'h0F: kw_name = "OPERATION";
        5'h10: kw_name = "QUESTIONABLE";
        5'h11: kw_name = "PRESET";
        5'h12: kw_name = "CONDITION";
        5'h13: kw_name = "ENABLE";
        5'h14: kw_name = "EVENT";
        5'h15: kw_name = "LEVEL";
        5'h16: kw_name = "IMMEDIATE";
        5'h17: kw_name = "TRIGGERED";
        5'h18: kw_name = "PROTECTION";
        5'h19: kw_name = "VOLTAGE";
        5'h1A: kw_name = "CURRENT";
        5'h1B: kw_name = "LEVEL";
        5'h1C: kw_name = "IMMEDIATE";
        5'h1D: kw_name = "PROTECTION";
        default: kw_name = {96{1'b0}};
      endcase
    end
  endfunction

  // {optional, parent}; parent 0 is the root
  function [5:0] kw_info;
    input [4:0] i;
    begin
      case (i)
        5'h08: kw_info = {1'b1, 5'h00};
        5'h0C, 5'h0D, 5'h0E: kw_info = {1'b0, 5'h08};
        5'h0F, 5'h10, 5'h11: kw_info = {1'b0, 5'h09};
        5'h12, 5'h13: kw_info = {1'b0, 5'h0F};
        5'h14: kw_info = {1'b1, 5'h0F};
        5'h15: kw_info = {1'b1, 5'h0C};
        5'h16: kw_info = {1'b1, 5'h15};
        5'h17: kw_info = {1'b0, 5'h15};
        5'h18: kw_info = {1'b0, 5'h0C};
        5'h19, 5'h1A: kw_info = {1'b0, 5'h06};
        5'h1B: kw_info = {1'b1, 5'h0D};
        5'h1C: kw_info = {1'b1, 5'h1B};
        5'h1D: kw_info = {1'b0, 5'h0D};
        default: kw_info = {1'b0, 5'h00};
      endcase
    end
  endfunction

  // Number of letters in a long spelling
  function [3:0] kw_len;
    input [95:0] nm;
    integer j;
    begin
      kw_len = 4'h0;
      for (j = 0; j < 12; j = j + 1) begin
        if (nm[8*j +: 8] != 8'h00) begin
          kw_len = j[3:0] + 4'h1;
        end
      end
    end
  endfunction

  // Short form length from the long form
  function [3:0] kw_short;
    input [95:0] nm;
    input [3:0] ln;
    reg [7:0] c4;
    begin
      c4 = 8'h00;
      if (ln > 4'h4) begin
        c4 = nm[8*(ln-4'h4) +: 8];
      end
      if (ln <= 4'h4) begin
        kw_short = ln;
      end else if (c4 == "A" || c4 == "E" || c4 == "I" ||
                   c4 == "O" || c4 == "U") begin
        kw_short = 4'h3;
      end else begin
        kw_short = 4'h4;
      end
    end
  endfunction

  // Search the children of p; an optional child is looked through
  function [5:0] kw_find;
    input [95:0] b;
    input [3:0] n;
    input [4:0] p;
    integer i;
    reg [95:0] nm;
    reg [3:0] ln;
    reg [3:0] sh;
    reg [5:0] inf;
    reg [5:0] pinf;
    reg ok;
    begin
      kw_find = 6'h00;
      for (i = `SMP_NODE_LAST; i >= 1; i = i - 1) begin
        nm = kw_name(i[4:0]);
        ln = kw_len(nm);
        sh = kw_short(nm, ln);
        inf = kw_info(i[4:0]);
        pinf = kw_info(inf[4:0]);
        ok = (inf[4:0] == p) || (pinf[5] && pinf[4:0] == p);
        // At most two accepted lengths; only one when the long form has four letters or fewer
        if (ok && n != 4'h0 && ((n == ln && b == nm) ||
            (n == sh && b == (nm >> (8*(ln-sh)))))) begin
          kw_find = {1'b1, i[4:0]};
        end
      end
    end
  endfunction

  // Folding keeps the keyword buffer comparable to the table
  function [7:0] upcase;
    input [7:0] c;
    begin
      if (c >= "a" && c <= "z") begin
        upcase = c - `SMP_CASE_OFS;
      end else begin
        upcase = c;
      end
    end
  endfunction

  function is_alnum;
    input [7:0] c;
    begin
      is_alnum = (c >= "A" && c <= "Z") || (c >= "0" && c <= "9");
    end
  endfunction

  // ----------------------------------------
  // Input buffering
  // ----------------------------------------
  wire [7:0] fo_data;
  wire fo_valid;
  wire take;

  smp_fifo #(
    .W(`SMP_DW),
    .D(`SMP_FIFO_DEPTH),
    .AW(`SMP_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fo_data),
    .out_valid(fo_valid),
    .out_ready(evt_ready)
  );

  // A stalled consumer stops parsing, so the FIFO fills and pushes back
  assign take = fo_valid & evt_ready;

  // ----------------------------------------
  // Parser state
  // ----------------------------------------
  reg [2:0] state_ff;
  reg [95:0] kw_ff;
  reg [3:0] len_ff;
  reg [4:0] parent_ff;
  reg [4:0] base_ff;
  reg [4:0] node_ff;
  reg query_ff;
  reg [2:0] nxt_state;
  reg [95:0] nxt_kw;
  reg [3:0] nxt_len;
  reg [4:0] nxt_parent;
  reg [4:0] nxt_base;
  reg [4:0] nxt_node;
  reg nxt_query;
  reg nxt_par_valid;
  reg do_emit;
  reg do_end;
  reg do_err;
  reg [7:0] ch;
  wire [5:0] res;
  wire [4:0] res_par;
  wire [5:0] res_inf;
  wire is_close;

  // Resolve the gathered keyword against the current level
  assign res = kw_find(kw_ff, len_ff, parent_ff);
  // Only the parent field is kept; the optional flag is not needed here
  assign res_inf = kw_info(res[4:0]);
  assign res_par = res_inf[4:0];
  assign is_close = (upcase(fo_data) == `SMP_CH_SEMI) ||
                    (fo_data == `SMP_CH_LF);

  // Next state for one character
  always @* begin
    nxt_state = state_ff;
    nxt_kw = kw_ff;
    nxt_len = len_ff;
    nxt_parent = parent_ff;
    nxt_base = base_ff;
    nxt_node = node_ff;
    nxt_query = query_ff;
    nxt_par_valid = 1'b0;
    do_emit = 1'b0;
    do_end = 1'b0;
    do_err = 1'b0;
    ch = upcase(fo_data);
    if (take && !is_close) begin
      case (state_ff)
        ST_START: begin
          if (ch == `SMP_CH_COLON) begin
            nxt_parent = `SMP_NODE_ROOT;
            nxt_kw = {96{1'b0}};
            nxt_len = 4'h0;
            nxt_state = ST_KW;
          end else if (ch == `SMP_CH_STAR) begin
            nxt_state = ST_COMMON;
            nxt_par_valid = 1'b1;
          end else if (is_alnum(ch)) begin
            nxt_parent = base_ff;
            nxt_kw = {88'h0, ch};
            nxt_len = 4'h1;
            nxt_state = ST_KW;
          end else if (ch != `SMP_CH_SP) begin
            do_err = 1'b1;
          end
        end
        ST_KW: begin
          if (is_alnum(ch)) begin
            if (len_ff < `SMP_KW_MAX) begin
              nxt_kw = {kw_ff[87:0], ch};
              nxt_len = len_ff + 4'h1;
            end else begin
              do_err = 1'b1;
            end
          end else if (!res[5]) begin
            do_err = 1'b1;
          end else if (ch == `SMP_CH_COLON) begin
            nxt_parent = res[4:0];
            nxt_kw = {96{1'b0}};
            nxt_len = 4'h0;
          end else if (ch == `SMP_CH_QMARK ||
                       ch == `SMP_CH_SP) begin
            nxt_node = res[4:0];
            nxt_base = res_par;
            nxt_query = (ch == `SMP_CH_QMARK);
            nxt_state = (ch == `SMP_CH_SP) ? ST_PARAM : ST_QRY;
          end else begin
            do_err = 1'b1;
          end
        end
        ST_QRY: begin
          // Only a space, then data, or a unit close may follow the query mark
          if (ch == `SMP_CH_SP) begin
            nxt_state = ST_PARAM;
          end else begin
            do_err = 1'b1;
          end
        end
        ST_PARAM: begin
          nxt_par_valid = 1'b1;
        end
        ST_COMMON: begin
          nxt_par_valid = 1'b1;
          if (ch == `SMP_CH_QMARK) begin
            nxt_query = 1'b1;
          end
        end
        ST_SKIP: begin
          nxt_state = ST_SKIP;
        end
        default: begin
          nxt_state = ST_SKIP;
        end
      endcase
    end
    // Unit close on semicolon or line feed
    if (take && is_close) begin
      if (state_ff == ST_KW && !res[5]) begin
        do_err = 1'b1;
      end else if (state_ff == ST_KW) begin
        nxt_node = res[4:0];
        nxt_base = res_par;
        do_emit = 1'b1;
      end else if (state_ff != ST_START && state_ff != ST_SKIP) begin
        do_emit = 1'b1;
      end
      nxt_state = ST_START;
      nxt_query = 1'b0;
      if (fo_data == `SMP_CH_LF) begin
        do_end = 1'b1;
        nxt_parent = `SMP_NODE_ROOT;
        nxt_base = `SMP_NODE_ROOT;
      end
    end else if (do_err) begin
      nxt_state = ST_SKIP;
      nxt_query = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_START;
      kw_ff <= {96{1'b0}};
      len_ff <= 4'h0;
      parent_ff <= `SMP_NODE_ROOT;
      base_ff <= `SMP_NODE_ROOT;
      node_ff <= `SMP_NODE_ROOT;
      query_ff <= 1'b0;
      unit_valid_ff <= 1'b0;
      unit_node_ff <= `SMP_NODE_ROOT;
      unit_query_ff <= 1'b0;
      unit_common_ff <= 1'b0;
      unit_err_ff <= 1'b0;
      msg_end_ff <= 1'b0;
      par_valid_ff <= 1'b0;
      par_data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      kw_ff <= nxt_kw;
      len_ff <= nxt_len;
      parent_ff <= nxt_parent;
      base_ff <= nxt_base;
      node_ff <= nxt_node;
      query_ff <= nxt_query;
      unit_valid_ff <= do_emit;
      unit_err_ff <= do_err;
      msg_end_ff <= do_end;
      par_valid_ff <= nxt_par_valid;
      // Raw byte kept so string data keeps its case
      if (nxt_par_valid) begin
        par_data_ff <= fo_data;
      end
      // Unit description holds until the next unit
      if (do_emit) begin
        unit_common_ff <= (state_ff == ST_COMMON);
        unit_query_ff <= query_ff;
        unit_node_ff <= (state_ff == ST_COMMON) ?
                        `SMP_NODE_ROOT : nxt_node;
      end
    end
  end
endmodule // smp_parser

// [smp_parser_assertions.sv]
// Port-level checks on the program message parser
`timescale 1ns/1ps
module smp_parser_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Stream and handshake
  input wire [7:0] in_data,
  input wire in_valid,
  input wire in_ready,
  input wire evt_ready,
  // Results
  input wire unit_valid_ff,
  input wire [4:0] unit_node_ff,
  input wire unit_query_ff,
  input wire unit_common_ff,
  input wire unit_err_ff,
  input wire msg_end_ff,
  input wire par_valid_ff,
  input wire [7:0] par_data_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  wire any_pulse = unit_valid_ff | unit_err_ff | msg_end_ff | par_valid_ff;

  // Reset must silence the stream ready output too, not only the pulses
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn |-> !any_pulse && !in_ready)
    else $error("outputs active during reset");
  a_ready_release: assert property ($rose(rstn) |=> in_ready)
    else $error("stream not ready after reset");
  a_no_valid_err: assert property (!(unit_valid_ff && unit_err_ff))
    else $error("unit both valid and bad");
  a_common_root: assert property (
    unit_valid_ff && unit_common_ff |-> unit_node_ff == 5'h00)
    else $error("common unit carries a tree node");
  a_node_range: assert property (
    unit_valid_ff && !unit_common_ff |-> unit_node_ff inside {[5'h01:5'h1D]})
    else $error("unit node outside the tree");
  // A pulse needs a byte consumed, which a stalled consumer forbids
  a_stall_quiet: assert property (any_pulse |-> $past(evt_ready))
    else $error("result pulse while stalled");
  a_par_holds: assert property (
    $changed(par_data_ff) |-> par_valid_ff)
    else $error("parameter byte changed without strobe");
  a_unit_holds: assert property (($changed(unit_node_ff) ||
    $changed(unit_query_ff)) |-> unit_valid_ff)
    else $error("unit fields changed without strobe");
  a_full_holds: assert property (!in_ready && !evt_ready |=> !in_ready)
    else $error("full buffer freed without draining");

  c_query: cover property (unit_valid_ff && unit_query_ff);
  c_err: cover property (unit_err_ff);
  c_full: cover property (!in_ready);
  c_common: cover property (unit_valid_ff && unit_common_ff);
endmodule // smp_parser_checker

bind smp_parser smp_parser_checker u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
  .evt_ready(evt_ready), .unit_valid_ff(unit_valid_ff),
  .unit_node_ff(unit_node_ff), .unit_query_ff(unit_query_ff),
  .unit_common_ff(unit_common_ff), .unit_err_ff(unit_err_ff),
  .msg_end_ff(msg_end_ff), .par_valid_ff(par_valid_ff),
  .par_data_ff(par_data_ff));

// [smp_host_model.sv]
// Controller model that offers command text one byte at a time
`timescale 1ns/1ps
module smp_host_model (
  // Clock
  input wire clk_sys,
  // Byte stream to the parser
  input wire in_ready,
  output logic [7:0] in_data,
  output logic in_valid
);
  int gap = 0;
  int n_taken = 0;
  logic hang = 1'b0;

  initial begin
    in_data = 8'h00;
    in_valid = 1'b0;
  end

  // Byte held until a rising edge sees ready; released data is inverted
  // so a stale byte can never pass for a fresh one
  task automatic send(input string s);
    int i;
    int k;
    for (i = 0; i < s.len(); i++) begin
      @(negedge clk_sys);
      in_data = s[i];
      in_valid = 1'b1;
      for (k = 0; k < 2000 && in_ready !== 1'b1; k++) @(negedge clk_sys);
      if (in_ready !== 1'b1) hang = 1'b1;
      @(posedge clk_sys);
      n_taken++;
      if (gap > 0 || i == s.len() - 1) begin
        @(negedge clk_sys);
        in_valid = 1'b0;
        in_data = ~in_data;
        repeat (gap) @(posedge clk_sys);
      end
    end
  endtask
endmodule // smp_host_model

// [smp_parser_tb_top.sv]
// Self-checking bench for the program message parser
`timescale 1ns/1ps
module smp_parser_tb_top;
  typedef struct {
    string cmd;
    int units;
    logic [4:0] node;
    logic q;
    int errs;
    string par;
  } smp_row_t;

  logic clk_sys = 1'b0;
  logic rstn = 1'b1;
  logic evt_ready = 1'b1;
  wire [7:0] in_data;
  wire in_valid, in_ready, unit_valid_ff, unit_query_ff, unit_common_ff;
  wire unit_err_ff, msg_end_ff, par_valid_ff;
  wire [4:0] unit_node_ff;
  wire [7:0] par_data_ff;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_units, n_errs, n_end, i;
  logic [4:0] last_node;
  logic last_q, last_c;
  string par_s;
  string kw[11] = '{"ABORT", "CAL", "DISP", "INIT", "LIST", "MEAS", "OUTP",
    "SOUR", "STAT", "SYST", "TRIG"};
  smp_row_t rows[16] = '{
    '{"VOLT 5\n", 1, 5'h0C, 1'b0, 0, "5"},
    '{"MEAS:VOLT?;CURR?\n", 2, 5'h1A, 1'b1, 0, ""},
    '{"MEAS:VOLT?;:CURR?\n", 2, 5'h0D, 1'b1, 0, ""},
    '{"SOUR:VOLT:LEV 4\n", 1, 5'h15, 1'b0, 0, "4"},
    '{"VOLT:TRIG 3\n", 1, 5'h17, 1'b0, 0, "3"},
    '{"volt:lev:imm 16\n", 1, 5'h16, 1'b0, 0, "16"},
    '{"MEASURE:CURRENT?\n", 1, 5'h1A, 1'b1, 0, ""},
    '{"VOLTA\n", 0, 5'h00, 1'b0, 1, ""},
    '{"VOLT:LEV:IMME 1\n", 0, 5'h00, 1'b0, 1, ""},
    '{"STAT:OPER:COND?;ENAB 16\n", 2, 5'h13, 1'b0, 0, "16"},
    '{"*IDN?\n", 1, 5'h00, 1'b1, 0, "*IDN?"},
    '{"VOLT?:LEV\n", 0, 5'h00, 1'b0, 1, ""},
    '{"VOLTA 1;CURR 2\n", 1, 5'h0D, 1'b0, 1, "2"},
    '{"MEAS:VOLT?\n", 1, 5'h19, 1'b1, 0, ""},
    '{"CURR?\n", 1, 5'h0D, 1'b1, 0, ""},
    '{"CURR:PROT?\n", 1, 5'h1D, 1'b1, 0, ""}};

  smp_parser dut (.clk_sys(clk_sys), .rstn(rstn), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .evt_ready(evt_ready),
    .unit_valid_ff(unit_valid_ff), .unit_node_ff(unit_node_ff),
    .unit_query_ff(unit_query_ff), .unit_common_ff(unit_common_ff),
    .unit_err_ff(unit_err_ff), .msg_end_ff(msg_end_ff),
    .par_valid_ff(par_valid_ff), .par_data_ff(par_data_ff));
  smp_host_model host (.clk_sys(clk_sys), .in_ready(in_ready),
    .in_data(in_data), .in_valid(in_valid));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Pulses are registered, so the falling edge sees them settled
  always @(negedge clk_sys) begin
    if (unit_valid_ff === 1'b1) begin
      n_units++;
      last_node = unit_node_ff;
      last_q = unit_query_ff;
      last_c = unit_common_ff;
    end
    if (unit_err_ff === 1'b1) n_errs++;
    if (msg_end_ff === 1'b1) n_end++;
    if (par_valid_ff === 1'b1) par_s = {par_s, string'(par_data_ff)};
  end

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One message in, then its results against the row; a stalled run
  // fills the buffer first with the consumer held off
  task automatic run_row(input smp_row_t r, input bit stall);
    int k;
    n_units = 0;
    n_errs = 0;
    n_end = 0;
    par_s = "";
    host.n_taken = 0;
    if (stall) begin
      evt_ready = 1'b0;
      fork
        host.send(r.cmd);
      join_none
      for (k = 0; k < 100 && in_ready !== 1'b0; k++) @(negedge clk_sys);
      chk("bytes taken when full", 32, host.n_taken);
      repeat (5) @(negedge clk_sys);
      chk("units while stalled", 0, n_units);
      evt_ready = 1'b1;
    end else begin
      host.send(r.cmd);
    end
    for (k = 0; k < 400 && n_end == 0; k++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    chk({"end ", r.cmd}, 1, n_end);
    chk({"units ", r.cmd}, r.units, n_units);
    chk({"errors ", r.cmd}, r.errs, n_errs);
    chk({"params ", r.cmd}, 1, par_s == r.par);
    chk("host hang", 0, host.hang);
    if (n_end == 0 || host.hang) wrap_up();
    if (r.units > 0) begin
      chk({"node ", r.cmd}, r.node, last_node);
      chk({"query ", r.cmd}, r.q, last_q);
      chk({"common ", r.cmd}, r.cmd[0] == "*", last_c);
    end
  endtask

  initial begin
    #1 rstn = 1'b0;
    // Twelve full rising edges pass while reset is held
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    // Ordinary cases, alternating prompt and slow controller pacing
    for (i = 0; i < 16; i++) begin
      host.gap = (i % 2) * 3;
      run_row(rows[i], 1'b0);
    end
    host.gap = 0;
    for (i = 0; i < 11; i++) begin
      run_row('{{kw[i], "\n"}, 1, 5'(i + 1), 1'b0, 0, ""}, 1'b0);
    end
    // Buffer filled to refusal, then drained back to back
    run_row('{"CURR 1;CURR 1;CURR 1;CURR 1;CURR 1;CURR 22\n", 6, 5'h0D,
      1'b0, 0, "1111122"}, 1'b1);
    // Reset in mid-message must drop the tree position to root
    host.send("MEAS:VOLT?;");
    repeat (4) @(negedge clk_sys);
    rstn = 1'b0;
    #1;
    chk("ready in reset", 0, in_ready);
    chk("pulses in reset", 0, {unit_valid_ff, msg_end_ff, par_valid_ff});
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    run_row(rows[14], 1'b0);
    wrap_up();
  end
endmodule // smp_parser_tb_top
